// ---- inc/usb_ep_regs.svh ----
// Register offsets, field positions, reset values of the endpoint block
`ifndef USB_EP_REGS_SVH
`define USB_EP_REGS_SVH
`define A_EPSEL   8'hC7
`define A_STATUS  8'hC8
`define A_TYPE    8'hC9
`define A_FDATA   8'hCF
`define A_CNTL    8'hE2
`define A_CNTH    8'hE3
`define A_IRQST   8'hF0
`define A_IRQMSK  8'hF1
`define B_TXC     0
`define B_RXO0    1
`define B_SETUP   2
`define B_STL     3
`define F_SETUP   4'h4
`define F_STL     4'h8
`define RST_FLAGS 4'h0
`define RST_MASK  8'h00
`define RST_BYTE  8'h00
`define CNT_W     11
`endif

// ---- inc/usb_ep_pkg.sv ----
// Types shared by the endpoint block
package usb_ep_pkg;
  typedef enum logic [1:0] {
    EP_CTRL = 2'b00,
    EP_ISO  = 2'b01,
    EP_BULK = 2'b10,
    EP_INTR = 2'b11
  } ep_type_t;
endpackage

// ---- verilog/ep_fifo.sv ----
// Byte FIFO of one endpoint, flip-flop storage
`timescale 1ns/1ns
module ep_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] din,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] dout,
  output logic                  full,
  output logic                  empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : g_bad_depth
    $error("ep_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      n_q, n_d;
  logic             do_push, do_pop;

  assign full  = (n_q == (AW+1)'(DEPTH));
  assign empty = (n_q == '0);
  assign dout  = mem_q[rp_q];

  always_comb
  begin
    mem_d   = mem_q;
    wp_d    = wp_q;
    rp_d    = rp_q;
    n_d     = n_q;
    do_pop  = pop && !empty && !clear;
    do_push = push && (clear || !full || do_pop);
    if (clear)
    begin
      wp_d = '0;
      rp_d = '0;
      n_d  = '0;
    end
    if (do_pop)
    begin
      rp_d = rp_q + 1'b1;
      n_d  = n_d - 1'b1;
    end
    if (do_push)
    begin
      mem_d[wp_d] = din;
      wp_d        = wp_d + 1'b1;
      n_d         = n_d + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
      wp_q <= '0;
      rp_q <= '0;
      n_q  <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      n_q   <= n_d;
    end
  end
endmodule // ep_fifo

// ---- verilog/usb_ep_status.sv ----
// Endpoint status flags, FIFO data port and byte count registers
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`include "usb_ep_regs.svh"
module usb_ep_status #(
  parameter int NUM_EP = 7,
  parameter int DEPTH  = 32,
  parameter int EPW    = 3
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [7:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              we,
  input  wire logic              re,
  output logic      [7:0]        rdata,
  output logic                   irq,
  input  wire logic [EPW-1:0]    usb_ep,
  input  wire logic              usb_setup,
  input  wire logic              usb_out_done,
  input  wire logic              usb_crc_err,
  input  wire logic              usb_in_done,
  input  wire logic              usb_stall_sent,
  input  wire logic              usb_rx_start,
  input  wire logic              usb_rx_valid,
  input  wire logic [7:0]        usb_rx_byte,
  input  wire logic              usb_rx_is_setup,
  input  wire logic              usb_tx_pop,
  output logic      [7:0]        usb_tx_byte,
  output logic      [NUM_EP-1:0] usb_out_nak
);
  localparam int CW = `CNT_W;

  // Mask, status and select each fit in one register byte
  if (NUM_EP < 1 || NUM_EP > 8 || EPW < 1 || EPW > 8 || (1 << EPW) < NUM_EP)
  begin : g_bad_ep
    $error("usb_ep_status: NUM_EP 1..8 and fitting EPW");
  end
  if (DEPTH >= (1 << CW))
  begin : g_bad_depth
    $error("usb_ep_status: DEPTH too large for count");
  end

  logic [EPW-1:0]              sel_q, sel_d;
  usb_ep_pkg::ep_type_t        type_q [NUM_EP];
  usb_ep_pkg::ep_type_t        type_d [NUM_EP];
  logic [NUM_EP-1:0][3:0]      flag_q, flag_d;
  logic [NUM_EP-1:0][CW-1:0]   cnt_q, cnt_d;
  logic [NUM_EP-1:0]           mask_q, mask_d;
  logic [NUM_EP-1:0]           ist_q, ist_d;
  logic [NUM_EP-1:0]           nak_d;
  logic [7:0]                  rdata_d, txb_d;
  logic                        irq_d;
  logic [NUM_EP-1:0]           fpush, fpop, fclr, fempty;
  logic [NUM_EP-1:0][7:0]      fdin, fdout;
  logic                        sel_ok, ep_ok, ep_iso, rx_ok, ev;

  assign sel_ok = (32'(sel_q) < NUM_EP);
  assign ep_ok  = (32'(usb_ep) < NUM_EP);
  assign ep_iso = ep_ok && (type_q[usb_ep] == usb_ep_pkg::EP_ISO);
  // Bank full refuses OUT bytes unless iso or setup data
  assign rx_ok  = ep_ok && (!flag_q[usb_ep][`B_RXO0] || ep_iso
                  || usb_rx_is_setup);
  assign ev     = ep_ok && (usb_setup || usb_out_done || usb_in_done
                  || (usb_stall_sent && !ep_iso));

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_fifo
      ep_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
      ) u_fifo (
        .clk   (clk),
        .rstn  (rstn),
        .clear (fclr[g]),
        .push  (fpush[g]),
        .din   (fdin[g]),
        .pop   (fpop[g]),
        .dout  (fdout[g]),
        .full  (),
        .empty (fempty[g])
      );
    end
  endgenerate

  always_comb
  begin
    sel_d   = sel_q;
    type_d  = type_q;
    flag_d  = flag_q;
    cnt_d   = cnt_q;
    mask_d  = mask_q;
    ist_d   = ist_q;
    rdata_d = `RST_BYTE;
    txb_d   = usb_tx_byte;
    fpush   = '0;
    fpop    = '0;
    fclr    = '0;
    fdin    = '0;
    nak_d   = '0;
    // Link side FIFO traffic
    if (usb_tx_pop && ep_ok)
    begin
      fpop[usb_ep] = 1'b1;
      txb_d        = fdout[usb_ep];
    end
    if (usb_rx_start && rx_ok)
    begin
      fclr[usb_ep]  = 1'b1;
      cnt_d[usb_ep] = '0;
    end
    if (usb_rx_valid && rx_ok)
    begin
      fpush[usb_ep] = 1'b1;
      fdin[usb_ep]  = usb_rx_byte;
      cnt_d[usb_ep] = cnt_d[usb_ep] + CW'(1);
    end
    // Firmware writes
    if (we)
    begin
      case (addr)
        `A_EPSEL:  sel_d = wdata[EPW-1:0];
        `A_STATUS:
          if (sel_ok)
          begin
            // Write zero clears; iso CRC bit is read-only
            flag_d[sel_q] = flag_q[sel_q] & (wdata[3:0]
              | ((type_q[sel_q] == usb_ep_pkg::EP_ISO) ? `F_STL : 4'h0));
          end
        `A_TYPE:
          if (sel_ok)
            type_d[sel_q] = usb_ep_pkg::ep_type_t'(wdata[1:0]);
        `A_FDATA:
          if (sel_ok && !fpush[sel_q])
          begin
            fpush[sel_q] = 1'b1;
            fdin[sel_q]  = wdata;
          end
        `A_IRQST:  ist_d = ist_q & ~wdata[NUM_EP-1:0];
        `A_IRQMSK: mask_d = wdata[NUM_EP-1:0];
        default: ;
      endcase
    end
    // Firmware reads, data one cycle later
    if (re && sel_ok)
    begin
      case (addr)
        `A_EPSEL:  rdata_d = 8'(sel_q);
        `A_STATUS: rdata_d = {4'h0, flag_q[sel_q]};
        `A_TYPE:   rdata_d = {6'h00, type_q[sel_q]};
        `A_FDATA:
        begin
          rdata_d = fdout[sel_q];
          if (!fpop[sel_q] && !fempty[sel_q])
            fpop[sel_q] = 1'b1;
        end
        `A_CNTL:   rdata_d = cnt_q[sel_q][7:0];
        `A_CNTH:   rdata_d = {5'h00, cnt_q[sel_q][CW-1:8]};
        `A_IRQST:  rdata_d = 8'(ist_q);
        `A_IRQMSK: rdata_d = 8'(mask_q);
        default:   rdata_d = `RST_BYTE;
      endcase
    end
    else if (re && addr == `A_EPSEL)
      rdata_d = 8'(sel_q);
    // Link events; set wins over a firmware clear
    if (ep_ok)
    begin
      if (usb_stall_sent && !ep_iso)
        flag_d[usb_ep][`B_STL] = 1'b1;
      if (usb_out_done)
      begin
        flag_d[usb_ep][`B_RXO0] = 1'b1;
        if (ep_iso)
          flag_d[usb_ep][`B_STL] = usb_crc_err;
      end
      if (usb_in_done)
        flag_d[usb_ep][`B_TXC] = 1'b1;
      if (usb_setup)
        flag_d[usb_ep] = `F_SETUP;
      if (ev)
        ist_d[usb_ep] = 1'b1;
    end
    for (int i = 0; i < NUM_EP; i++)
      nak_d[i] = flag_d[i][`B_RXO0] && (type_d[i] != usb_ep_pkg::EP_ISO);
    irq_d = |(ist_d & mask_d);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_q       <= '0;
      for (int i = 0; i < NUM_EP; i++)
        type_q[i] <= usb_ep_pkg::EP_CTRL;
      flag_q      <= '0;
      cnt_q       <= '0;
      mask_q      <= '0;
      ist_q       <= '0;
      rdata       <= `RST_BYTE;
      usb_tx_byte <= `RST_BYTE;
      usb_out_nak <= '0;
      irq         <= 1'b0;
    end
    else
    begin
      sel_q       <= sel_d;
      type_q      <= type_d;
      flag_q      <= flag_d;
      cnt_q       <= cnt_d;
      mask_q      <= mask_d;
      ist_q       <= ist_d;
      rdata       <= rdata_d;
      usb_tx_byte <= txb_d;
      usb_out_nak <= nak_d;
      irq         <= irq_d;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_setup_ev;
    usb_setup && ep_ok;
  endsequence

  sequence s_masked_ev;
    ev && mask_q[usb_ep] && !(we && (addr == `A_IRQMSK || addr == `A_IRQST));
  endsequence

  a_setup_clears: assert property (
    s_setup_ev |=> flag_q[$past(usb_ep)] == `F_SETUP
  ) else $error("setup did not leave only the setup flag");

  a_out_flag: assert property (
    usb_out_done && ep_ok && !usb_setup |=> flag_q[$past(usb_ep)][`B_RXO0]
  ) else $error("OUT packet did not set bank-0 flag");

  a_in_flag: assert property (
    usb_in_done && ep_ok && !usb_setup |=> flag_q[$past(usb_ep)][`B_TXC]
  ) else $error("IN completion did not set transmit flag");

  a_stall_flag: assert property (
    usb_stall_sent && ep_ok && !ep_iso && !usb_setup
      |=> flag_q[$past(usb_ep)][`B_STL]
  ) else $error("stall sent did not set stall flag");

  a_iso_crc: assert property (
    usb_out_done && ep_iso && !usb_setup
      |=> flag_q[$past(usb_ep)][`B_STL] == $past(usb_crc_err)
  ) else $error("iso CRC bit not refreshed");

  a_nak_hold: assert property (
    usb_rx_valid && ep_ok && flag_q[usb_ep][`B_RXO0] && !ep_iso
      && !usb_rx_is_setup
      |=> cnt_q[$past(usb_ep)] == $past(cnt_q[usb_ep])
  ) else $error("byte accepted while bank 0 full");

  a_count_inc: assert property (
    usb_rx_valid && rx_ok && !usb_rx_start
      |=> cnt_q[$past(usb_ep)] == $past(cnt_q[usb_ep]) + CW'(1)
  ) else $error("byte count did not advance");

  a_cnth_zero: assert property (
    re && addr == `A_CNTH |=> rdata[7:3] == 5'h00
  ) else $error("count high upper bits not zero");

  a_nak_level: assert property (
    usb_out_done && ep_ok && !ep_iso && !usb_setup && !we
      |=> usb_out_nak[$past(usb_ep)]
  ) else $error("bank-0 flag set but OUT not refused");

  a_iso_no_stall: assert property (
    usb_stall_sent && ep_iso && !usb_out_done && !usb_setup && !we
      |=> flag_q[$past(usb_ep)][`B_STL] == $past(flag_q[usb_ep][`B_STL])
  ) else $error("stall event changed iso CRC bit");

  a_pop_byte: assert property (
    usb_tx_pop && ep_ok && !fempty[usb_ep]
      |=> usb_tx_byte == $past(fdout[usb_ep])
  ) else $error("popped byte not presented to link");

  a_irq_rise: assert property (
    s_masked_ev |-> ##1 irq
      ##1 (irq || $past(we && (addr == `A_IRQST || addr == `A_IRQMSK)))
  ) else $error("masked event did not raise interrupt");
endmodule // usb_ep_status

// ---- bench/usb_link_model.sv ----
// Link engine model: packet, IN pop and handshake events toward the block
`timescale 1ns/1ns
module usb_link_model (
  input  wire logic       clk,
  input  wire logic [7:0] usb_tx_byte,
  output logic      [2:0] usb_ep,
  output logic            usb_setup,
  output logic            usb_out_done,
  output logic            usb_crc_err,
  output logic            usb_in_done,
  output logic            usb_stall_sent,
  output logic            usb_rx_start,
  output logic            usb_rx_valid,
  output logic      [7:0] usb_rx_byte,
  output logic            usb_rx_is_setup,
  output logic            usb_tx_pop
);
  initial
  begin
    {usb_ep, usb_setup, usb_out_done, usb_crc_err, usb_in_done} = '0;
    {usb_stall_sent, usb_rx_start, usb_rx_valid, usb_rx_byte} = '0;
    {usb_rx_is_setup, usb_tx_pop} = '0;
  end
  // Data packet: start, n bytes after the PID, then setup or out completion
  task automatic pkt(input logic [2:0] ep, input logic st, input int n,
                     input logic [7:0] b, input logic crc);
    @(posedge clk);
    usb_ep <= ep;
    usb_rx_is_setup <= st;
    usb_rx_start <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      usb_rx_start <= 1'b0;
      usb_rx_valid <= 1'b1;
      usb_rx_byte <= 8'(b + i);
    end
    @(posedge clk);
    usb_rx_start <= 1'b0;
    usb_rx_valid <= 1'b0;
    usb_rx_byte <= ~usb_rx_byte;
    usb_crc_err <= crc;
    usb_setup <= st;
    usb_out_done <= ~st;
    @(posedge clk);
    usb_setup <= 1'b0;
    usb_out_done <= 1'b0;
    usb_crc_err <= ~crc;
    usb_rx_is_setup <= ~st;
    #1;
  endtask
  // One IN byte taken from the endpoint FIFO
  task automatic pop(input logic [2:0] ep, output logic [7:0] d);
    @(posedge clk);
    usb_ep <= ep;
    usb_tx_pop <= 1'b1;
    @(posedge clk);
    usb_tx_pop <= 1'b0;
    #1 d = usb_tx_byte;
  endtask
  // IN acknowledged, or STALL handshake sent
  task automatic ev(input logic [2:0] ep, input logic stall);
    @(posedge clk);
    usb_ep <= ep;
    usb_stall_sent <= stall;
    usb_in_done <= ~stall;
    @(posedge clk);
    usb_stall_sent <= 1'b0;
    usb_in_done <= 1'b0;
    #1;
  endtask
endmodule // usb_link_model

// ---- bench/testbench.sv ----
// Self-checking bench of the endpoint status and FIFO access block
`timescale 1ns/1ns
`include "usb_ep_regs.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
module testbench;
  logic       clk, rstn, we, re, irq;
  logic [7:0] addr, wdata, rdata, v, b, usb_tx_byte, usb_rx_byte;
  logic [2:0] usb_ep;
  logic [6:0] usb_out_nak;
  logic       usb_setup, usb_out_done, usb_crc_err, usb_in_done, usb_stall_sent;
  logic       usb_rx_start, usb_rx_valid, usb_rx_is_setup, usb_tx_pop;
  int         num_errors, compares, n;
  integer     seed;
  usb_ep_status #(.NUM_EP(7), .DEPTH(512), .EPW(3)) dut_u (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .irq(irq), .usb_ep(usb_ep), .usb_setup(usb_setup),
    .usb_out_done(usb_out_done), .usb_crc_err(usb_crc_err),
    .usb_in_done(usb_in_done), .usb_stall_sent(usb_stall_sent),
    .usb_rx_start(usb_rx_start), .usb_rx_valid(usb_rx_valid),
    .usb_rx_byte(usb_rx_byte), .usb_rx_is_setup(usb_rx_is_setup),
    .usb_tx_pop(usb_tx_pop), .usb_tx_byte(usb_tx_byte), .usb_out_nak(usb_out_nak));
  usb_link_model link_u (
    .clk(clk), .usb_tx_byte(usb_tx_byte), .usb_ep(usb_ep), .usb_setup(usb_setup),
    .usb_out_done(usb_out_done), .usb_crc_err(usb_crc_err),
    .usb_in_done(usb_in_done), .usb_stall_sent(usb_stall_sent),
    .usb_rx_start(usb_rx_start), .usb_rx_valid(usb_rx_valid),
    .usb_rx_byte(usb_rx_byte), .usb_rx_is_setup(usb_rx_is_setup),
    .usb_tx_pop(usb_tx_pop));
  always #5 clk = ~clk;
  function automatic logic [7:0] pat(input logic [7:0] b, input int i);
    return 8'(b + i);
  endfunction
  function automatic logic [7:0] hi(input int n);
    return {5'h0, 3'(n >> 8)};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #900_000;
    num_errors++;
    wrap_up();
  end
  initial
  begin
    seed = 32'h073e;
    {clk, rstn, we, re, addr, wdata, num_errors, compares} = '0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rdc(`A_CNTL, `RST_BYTE);
    rdc(`A_CNTH, 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      n = (k == 0) ? 300 : 1 + ($random(seed) & 31);
      b = 8'($random(seed));
      wr(`A_EPSEL, 8'(k));
      wr(`A_TYPE, k[0] ? 8'h02 : 8'h00);
      wr(`A_IRQMSK, k[0] ? 8'hff : 8'h00);
      link_u.pkt(3'(k), 1'b0, n, b, 1'b0);
      `CHK(usb_out_nak[k], 1'b1)
      `CHK(irq, k[0])
      rdc(`A_STATUS, 8'h02);
      rdc(`A_CNTL, 8'(n));
      rdc(`A_CNTH, hi(n));
      link_u.pkt(3'(k), 1'b0, 5, ~b, 1'b0);
      rdc(`A_CNTL, 8'(n));
      for (int i = 0; i < n; i++)
        rdc(`A_FDATA, pat(b, i));
      wr(`A_STATUS, 8'h00);
      wr(`A_IRQST, 8'hff);
      `CHK(usb_out_nak[k], 1'b0)
      `CHK(irq, 1'b0)
    end
    wr(`A_EPSEL, 8'h00);
    link_u.pkt(3'd0, 1'b0, 4, 8'h10, 1'b0);
    link_u.ev(3'd0, 1'b0);
    link_u.pkt(3'd0, 1'b1, 8, 8'h40, 1'b0);
    rdc(`A_STATUS, `F_SETUP);
    rdc(`A_CNTL, 8'h08);
    for (int i = 0; i < 8; i++)
      rdc(`A_FDATA, pat(8'h40, i));
    wr(`A_STATUS, 8'h00);
    wr(`A_IRQST, 8'hff);
    wr(`A_EPSEL, 8'h02);
    wr(`A_TYPE, 8'h03);
    link_u.ev(3'd2, 1'b1);
    rdc(`A_STATUS, `F_STL);
    `CHK(irq, 1'b1)
    wr(`A_EPSEL, 8'h03);
    wr(`A_TYPE, 8'h02);
    b = 8'($random(seed));
    for (int i = 0; i < 3; i++)
      wr(`A_FDATA, pat(b, i));
    for (int i = 0; i < 3; i++)
    begin
      link_u.pop(3'd3, v);
      `CHK(v, pat(b, i))
    end
    link_u.ev(3'd3, 1'b0);
    rdc(`A_STATUS, 8'h01);
    wr(`A_EPSEL, 8'h04);
    wr(`A_TYPE, 8'h01);
    link_u.pkt(3'd4, 1'b0, 3, b, 1'b1);
    link_u.ev(3'd4, 1'b1);
    rdc(`A_STATUS, 8'h0a);
    `CHK(usb_out_nak[4], 1'b0)
    wr(`A_STATUS, 8'h00);
    rdc(`A_STATUS, 8'h08);
    link_u.pkt(3'd4, 1'b0, 2, b, 1'b0);
    rdc(`A_STATUS, 8'h02);
    rdc(`A_CNTL, 8'h02);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    `CHK(irq, 1'b0)
    rdc(`A_CNTL, `RST_BYTE);
    wr(`A_EPSEL, 8'h07);
    rdc(`A_STATUS, 8'h00);
    rdc(8'h55, 8'h00);
    wrap_up();
  end
endmodule // testbench
